//--- hdl/egf_fmt.sv
/*
 Formats the head FIFO entry into the 16-bit read word.
 Assumes head fields are stable while the word is sampled.
*/
`timescale 1ns/1ps
module egf_fmt (
    egf_store_if.view sif,
    input wire logic tag_en,
    input wire logic narrow,
    output logic [egf_pkg::WORD_W-1:0] word
);
    logic [egf_pkg::CHAN_W-1:0] tag;
    logic [egf_pkg::RES_W-1:0] res;
    logic [egf_pkg::RES_W-1:0] narrow_res;

    // Channel number passes straight through as binary
    assign tag = (tag_en & ~sif.empty) ? sif.head_chan : '0;
    // Narrowing happens here so queued entries follow the live option
    assign narrow_res = egf_pkg::RES_W'(sif.head_res >> egf_pkg::NARROW_LSB);
    assign res = sif.empty ? '0 : (narrow ? narrow_res : sif.head_res);
    assign word = {sif.empty, 1'b0, tag, res};
endmodule : egf_fmt

//--- hdl/egf_pkg.sv
/*
 Constants for the event-group result FIFO read port: register map,
 field positions, widths and the FIFO depth.
 Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package egf_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned CHAN_W = 4;
    localparam int unsigned RES_W = 10;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [ADDR_W-1:0] BUFFER_CONTROL_TWO_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] QUEUE_STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] WINDOW_BASE_ADDR = 8'h20;
    localparam logic [ADDR_W-1:0] WINDOW_MASK = 8'he0;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Fields
    localparam int unsigned CTL_BUFFERED_BIT = 0;
    localparam int unsigned CTL_TAG_EN_BIT = 1;
    localparam int unsigned CTL_NARROW_BIT = 2;
    localparam int unsigned CTL_W = 3;
    localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;

    localparam int unsigned ST_EMPTY_BIT = 0;
    localparam int unsigned ST_FULL_BIT = 1;
    localparam int unsigned ST_OVERRUN_BIT = 2;
    localparam int unsigned ST_SUSPEND_BIT = 3;
    localparam int unsigned ST_COUNT_LSB = 8;

    localparam int unsigned W_EMPTY_BIT = 15;
    localparam int unsigned W_RSVD_BIT = 14;
    localparam int unsigned W_TAG_LSB = 10;
    localparam int unsigned NARROW_LSB = 2;

    typedef enum logic {
        EGF_IDLE = 1'b0,
        EGF_RESP = 1'b1
    } egf_apb_state_t;

endpackage : egf_pkg

//--- hdl/egf_read_port.sv
/*
 Event-group result FIFO read port with its APB slave and control.
 Assumes the converter sequencer and debug logic run on mclk; the
 sequencer watches seq_full and the overrun level comes from elsewhere.
*/
`timescale 1ns/1ps
module egf_read_port (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [egf_pkg::ADDR_W-1:0] paddr,
    input wire logic [egf_pkg::DATA_W-1:0] pwdata,
    input wire logic [egf_pkg::STRB_W-1:0] pstrb,
    output logic [egf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic seq_push,
    input wire logic [egf_pkg::CHAN_W-1:0] seq_channel,
    input wire logic [egf_pkg::RES_W-1:0] seq_result,
    input wire logic fifo_overrun,
    input wire logic debug_suspend,
    output logic seq_full,
    output logic queue_vacant_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    egf_store_if sif();

    egf_pkg::egf_apb_state_t state_r;
    egf_pkg::egf_apb_state_t state_nxt;

    logic [egf_pkg::DATA_W-1:0] prdata_r;
    logic [egf_pkg::DATA_W-1:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [egf_pkg::CTL_W-1:0] ctl_r;
    logic [egf_pkg::CTL_W-1:0] ctl_nxt;

    logic buffered_mode;
    logic channel_tag_enable;
    logic narrow_result_select;

    logic aligned;
    logic sel_ctl;
    logic sel_stat;
    logic sel_win_raw;
    logic sel_win;
    logic mapped;

    logic take;
    logic done;
    logic ctl_write;
    logic win_read;
    logic pop_ok;

    logic [egf_pkg::WORD_W-1:0] window_word;
    logic [egf_pkg::DATA_W-1:0] ctl_word;
    logic [egf_pkg::DATA_W-1:0] stat_word;
    logic [egf_pkg::DATA_W-1:0] win_word32;
    logic [egf_pkg::DATA_W-1:0] read_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    egf_store u_store (
        .mclk(mclk),
        .reset(reset),
        .sif(sif.store)
    );

    egf_fmt u_fmt (
        .sif(sif.view),
        .tag_en(channel_tag_enable),
        .narrow(narrow_result_select),
        .word(window_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control fields
    assign buffered_mode = ctl_r[egf_pkg::CTL_BUFFERED_BIT];
    assign channel_tag_enable = ctl_r[egf_pkg::CTL_TAG_EN_BIT];
    assign narrow_result_select = ctl_r[egf_pkg::CTL_NARROW_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign aligned = (paddr[1:0] == egf_pkg::WORD_ALIGN);
    assign sel_ctl = aligned & (paddr == egf_pkg::BUFFER_CONTROL_TWO_ADDR);
    assign sel_stat = aligned & (paddr == egf_pkg::QUEUE_STATUS_ADDR);
    // Eight word aliases so a burst load drains up to eight entries
    assign sel_win_raw = aligned & ((paddr & egf_pkg::WINDOW_MASK) == egf_pkg::WINDOW_BASE_ADDR);
    // Outside buffered mode the window answers as unmapped
    assign sel_win = sel_win_raw & buffered_mode;
    assign mapped = sel_ctl | sel_stat | sel_win;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer phases
    // First access cycle captures read data; pready rises on the next
    assign take = psel & penable & (state_r == egf_pkg::EGF_IDLE);
    assign done = psel & penable & pready_r;
    assign ctl_write = done & pwrite & sel_ctl & pstrb[0];
    assign win_read = done & ~pwrite & sel_win;

    // Validity comes from the captured word: a push landing between
    // capture and completion must not pop an entry never returned
    assign pop_ok = win_read & ~prdata_r[egf_pkg::W_EMPTY_BIT] & ~fifo_overrun & ~debug_suspend;

    ////////////////////////////////////////////////////////////////////////////
    // FIFO push and pop controls
    assign sif.push = seq_push;
    assign sif.push_chan = seq_channel;
    assign sif.push_res = seq_result;
    assign sif.pop = pop_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Read words
    assign ctl_word = {{(egf_pkg::DATA_W-egf_pkg::CTL_W){1'b0}}, ctl_r};

    always_comb begin
        stat_word = '0;
        stat_word[egf_pkg::ST_EMPTY_BIT] = sif.empty;
        stat_word[egf_pkg::ST_FULL_BIT] = sif.full;
        stat_word[egf_pkg::ST_OVERRUN_BIT] = fifo_overrun;
        stat_word[egf_pkg::ST_SUSPEND_BIT] = debug_suspend;
        stat_word[egf_pkg::ST_COUNT_LSB +: egf_pkg::CNT_W] = sif.count;
    end

    // Upper half zero; a write here changes nothing
    assign win_word32 = {{(egf_pkg::DATA_W-egf_pkg::WORD_W){1'b0}}, window_word};

    assign read_mux = sel_ctl ? ctl_word :
                      sel_stat ? stat_word :
                      sel_win ? win_word32 :
                      '0;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        case (state_r)
            egf_pkg::EGF_IDLE: begin
                if (take) begin
                    state_nxt = egf_pkg::EGF_RESP;
                    prdata_nxt = pwrite ? '0 : read_mux;
                    pslverr_nxt = ~mapped;
                end
            end
            egf_pkg::EGF_RESP: begin
                if (done) begin
                    state_nxt = egf_pkg::EGF_IDLE;
                    pslverr_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = egf_pkg::EGF_IDLE;
                pslverr_nxt = 1'b0;
            end
        endcase
    end

    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_write) begin
            ctl_nxt = pwdata[egf_pkg::CTL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= egf_pkg::EGF_IDLE;
            pready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pready_r <= (state_nxt == egf_pkg::EGF_RESP);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl_r <= egf_pkg::CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign seq_full = sif.full;
    assign queue_vacant_flag = sif.empty;

endmodule : egf_read_port

//--- hdl/egf_store.sv
/*
 Result FIFO store: array of channel tag plus 10-bit result.
 Ignores a push when full and a pop when empty.
*/
`timescale 1ns/1ps
module egf_store (
    input wire logic mclk,
    input wire logic reset,
    egf_store_if.store sif
);
    logic [egf_pkg::CHAN_W+egf_pkg::RES_W-1:0] mem [egf_pkg::DEPTH];
    logic [egf_pkg::PTR_W-1:0] wr_ptr_r;
    logic [egf_pkg::PTR_W-1:0] rd_ptr_r;
    logic [egf_pkg::CNT_W-1:0] count_r;
    logic [egf_pkg::CNT_W-1:0] count_nxt;
    logic do_push;
    logic do_pop;

    assign do_push = sif.push & ~sif.full;
    assign do_pop = sif.pop & ~sif.empty;
    assign count_nxt = count_r + {{(egf_pkg::CNT_W-1){1'b0}}, do_push}
                     - {{(egf_pkg::CNT_W-1){1'b0}}, do_pop};

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= {sif.push_chan, sif.push_res};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            sif.empty <= 1'b1;
            sif.full <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_r + egf_pkg::PTR_W'(do_push);
            rd_ptr_r <= rd_ptr_r + egf_pkg::PTR_W'(do_pop);
            count_r <= count_nxt;
            sif.empty <= (count_nxt == '0);
            sif.full <= (count_nxt == egf_pkg::CNT_W'(egf_pkg::DEPTH));
        end
    end

    // Head is the oldest entry
    assign sif.head_chan = mem[rd_ptr_r][egf_pkg::CHAN_W+egf_pkg::RES_W-1:egf_pkg::RES_W];
    assign sif.head_res = mem[rd_ptr_r][egf_pkg::RES_W-1:0];
    assign sif.count = count_r;
endmodule : egf_store

//--- hdl/egf_store_if.sv
/*
 Carrier between the read port top, its FIFO store and its formatter.
 Assumes all three sit on mclk.
*/
`timescale 1ns/1ps
interface egf_store_if;
    logic push;
    logic [egf_pkg::CHAN_W-1:0] push_chan;
    logic [egf_pkg::RES_W-1:0] push_res;
    logic pop;
    logic [egf_pkg::CHAN_W-1:0] head_chan;
    logic [egf_pkg::RES_W-1:0] head_res;
    logic empty;
    logic full;
    logic [egf_pkg::CNT_W-1:0] count;

    modport store (input push, push_chan, push_res, pop,
                   output head_chan, head_res, empty, full, count);
    modport user (output push, push_chan, push_res, pop,
                  input head_chan, head_res, empty, full, count);
    modport view (input head_chan, head_res, empty);
endinterface : egf_store_if

//--- sim/egf_host.sv
/*
 Host model: APB master issuing single or chained transfers.
 Assumes xfer is entered just after a rising edge of mclk.
*/
`timescale 1ns/1ps
module egf_host (
    input wire logic mclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // Chained calls keep psel high, so a burst has no idle cycle
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic last,
              output logic [31:0] r, output logic e);
        if (!psel)
            psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
        if (last) begin
            psel <= 1'b0;
            @(posedge mclk);
        end
    endtask : xfer
endmodule : egf_host

//--- sim/egf_read_port_chk.sv
/*
 Port checker for the event FIFO read port.
 Assumes an APB master that holds each request until pready.
*/
`timescale 1ns/1ps
module egf_read_port_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [egf_pkg::ADDR_W-1:0] paddr,
    input wire logic [egf_pkg::DATA_W-1:0] pwdata,
    input wire logic [egf_pkg::STRB_W-1:0] pstrb,
    input wire logic [egf_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic seq_push,
    input wire logic [egf_pkg::CHAN_W-1:0] seq_channel,
    input wire logic [egf_pkg::RES_W-1:0] seq_result,
    input wire logic fifo_overrun,
    input wire logic debug_suspend,
    input wire logic seq_full,
    input wire logic queue_vacant_flag
);
    logic [2:0] ctl_r;
    wire done = psel && penable && pready;
    wire win = done && !pwrite && paddr[1:0] == 2'h0
        && (paddr & egf_pkg::WINDOW_MASK) == egf_pkg::WINDOW_BASE_ADDR;

    // Shadow of the control register, so checks know the mode
    always_ff @(posedge mclk) begin
        if (reset)
            ctl_r <= 3'h0;
        else if (done && pwrite && paddr == 8'h00 && pstrb[0])
            ctl_r <= pwdata[2:0];
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    property p_rst; $fell(reset) |-> queue_vacant_flag && !pready && prdata == 32'h0; endproperty
    property p_empty; win && !pslverr |-> prdata[15] == $past(queue_vacant_flag); endproperty
    property p_rsvd; win |-> !prdata[14] && prdata[31:16] == 16'h0; endproperty
    property p_blank; win && prdata[15] |-> prdata[13:0] == 14'h0; endproperty
    property p_gate; win |-> pslverr == !ctl_r[0]; endproperty
    property p_tag; win && !ctl_r[1] |-> prdata[13:10] == 4'h0; endproperty
    property p_narrow; win && ctl_r[2] |-> prdata[9:8] == 2'h0; endproperty
    property p_ovr; win && fifo_overrun && !seq_push |=> $stable(queue_vacant_flag); endproperty
    property p_sus; win && debug_suspend && !seq_push |=> $stable(queue_vacant_flag); endproperty

    a_rst: assert property (p_rst) else $error("state after reset wrong");
    a_empty: assert property (p_empty) else $error("empty bit wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    a_blank: assert property (p_blank) else $error("empty word not blank");
    a_gate: assert property (p_gate) else $error("window gating wrong");
    a_tag: assert property (p_tag) else $error("tag shown while off");
    a_narrow: assert property (p_narrow) else $error("narrow high bits set");
    a_ovr: assert property (p_ovr) else $error("pop during overrun");
    a_sus: assert property (p_sus) else $error("pop during suspend");

    c_valid: cover property (win && !pslverr && !prdata[15]);
    c_full: cover property (seq_full);
    c_sus: cover property (win && debug_suspend);
endmodule : egf_read_port_chk

bind egf_read_port egf_read_port_chk u_egf_read_port_chk (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_push(seq_push), .seq_channel(seq_channel),
    .seq_result(seq_result), .fifo_overrun(fifo_overrun), .debug_suspend(debug_suspend),
    .seq_full(seq_full), .queue_vacant_flag(queue_vacant_flag)
);

//--- sim/test_event_group_fifo_read_port.sv
/*
 Self-checking bench for the event FIFO read port.
 Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
module test_event_group_fifo_read_port;
    typedef struct {logic [2:0] ctl; logic [3:0] ch; logic [9:0] res; logic [15:0] exp;} egf_row_t;
    egf_row_t rows [4] = '{'{3'h1, 4'h5, 10'h3a5, 16'h03a5}, '{3'h3, 4'hb, 10'h2c3, 16'h2ec3},
                           '{3'h7, 4'he, 10'h3ff, 16'h38ff}, '{3'h5, 4'h0, 10'h155, 16'h0055}};
    logic mclk, reset, seq_push, fifo_overrun, debug_suspend, err;
    logic psel, penable, pwrite, pready, pslverr, seq_full, queue_vacant_flag;
    logic [3:0] seq_channel, pstrb;
    logic [9:0] seq_result;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;

    egf_read_port u_egf_read_port (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .seq_push(seq_push), .seq_channel(seq_channel),
        .seq_result(seq_result), .fifo_overrun(fifo_overrun), .debug_suspend(debug_suspend),
        .seq_full(seq_full), .queue_vacant_flag(queue_vacant_flag));
    egf_host u_egf_host (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));

    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task push(input logic [3:0] ch, input logic [9:0] res);
        seq_push <= 1'b1;
        seq_channel <= ch;
        seq_result <= res;
        @(posedge mclk);
        seq_push <= 1'b0;
        @(posedge mclk);
    endtask : push
    task rd_win(input logic [7:0] a, input logic last, input logic [15:0] exp);
        u_egf_host.xfer(1'b0, a, 32'h0, last, rd, err);
        chk("window", rd, {16'h0, exp});
    endtask : rd_win
    task wr_ctl(input logic [2:0] v);
        u_egf_host.xfer(1'b1, 8'h00, {29'h0, v}, 1'b1, rd, err);
    endtask : wr_ctl

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        reset = 1'b1;
        seq_push = 1'b0;
        seq_channel = 4'h0;
        seq_result = 10'h0;
        fifo_overrun = 1'b0;
        debug_suspend = 1'b0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk("vacant", {31'h0, queue_vacant_flag}, 32'h1);
        rd_win(8'h20, 1'b1, 16'h0000);
        chk("error", {31'h0, err}, 32'h1);
        wr_ctl(3'h1);
        u_egf_host.xfer(1'b1, 8'h24, 32'hffffffff, 1'b1, rd, err);
        rd_win(8'h3c, 1'b1, 16'h8000);
        foreach (rows[i]) begin
            push(rows[i].ch, rows[i].res);
            wr_ctl(rows[i].ctl);
            rd_win(8'(32 + 4 * i), 1'b1, rows[i].exp);
        end
        wr_ctl(3'h3);
        for (int i = 0; i < 16; i++)
            push(4'(i), 10'(i * 33));
        chk("full", {31'h0, seq_full}, 32'h1);
        chk("vacant", {31'h0, queue_vacant_flag}, 32'h0);
        for (int i = 0; i < 16; i++)
            rd_win(8'(32 + 4 * (i % 8)), i == 15, {2'h0, 4'(i), 10'(i * 33)});
        rd_win(8'h20, 1'b1, 16'h8000);
        chk("full", {31'h0, seq_full}, 32'h0);
        chk("vacant", {31'h0, queue_vacant_flag}, 32'h1);
        for (int k = 0; k < 2; k++) begin
            push(4'h7, 10'h2aa);
            fifo_overrun <= (k == 0);
            debug_suspend <= (k == 1);
            rd_win(8'h28, 1'b1, 16'h1eaa);
            rd_win(8'h2c, 1'b1, 16'h1eaa);
            fifo_overrun <= 1'b0;
            debug_suspend <= 1'b0;
            rd_win(8'h30, 1'b1, 16'h1eaa);
            rd_win(8'h34, 1'b1, 16'h8000);
        end
        print_verdict();
    end
endmodule : test_event_group_fifo_read_port
